/* File: rtl/uim_regs.sv */
`timescale 1ns/1ps
module uim_regs
	import uim_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ce_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [7:0]       rdata_o,
	input  wire logic [7:0]  rx_data_i,
	input  wire logic [6:0]  rx_level_i,
	input  wire logic [2:0]  rx_top_err_i,
	input  wire logic        rx_any_err_i,
	input  wire logic        rx_push_i,
	input  wire logic [2:0]  rx_push_err_i,
	input  wire logic        rx_overrun_i,
	input  wire logic [6:0]  tx_level_i,
	input  wire logic        tx_shift_empty_i,
	input  wire logic [7:0]  modem_status_i,
	output logic             rx_pop_o,
	output logic             tx_push_o,
	output logic [7:0]       tx_data_o,
	output logic             modem_status_rd_o,
	output logic             rx_fifo_rst_o,
	output logic             tx_fifo_rst_o,
	output logic             fifo_en_o,
	output logic [15:0]      divisor_o,
	output logic [3:0]       frac_div_o,
	output logic [7:0]       line_control_o,
	output logic [7:0]       modem_control_o,
	output logic [7:0]       feature_control_o,
	output logic [7:0]       enhanced_function_o,
	output logic [7:0]       enhanced_mode_select_o,
	output logic [7:0]       rx_trigger_o,
	output logic [7:0]       tx_trigger_o,
	output logic             irq_o
);
	// ****************************************
	// decode
	// ****************************************
	logic [7:0] lcr_q, ier_q, fcr_q, mcr_q, scr_q, enhanced_mode_select_q, feature_control_q, efr_q;
	logic [7:0] dll_q, dlm_q, dld_q, rtrg_q, ttrg_q;
	logic [7:0] res1_q, res2_q, pau1_q, pau2_q;
	logic [7:0] rdata_d;
	logic       ovr_q, imm_q;
	logic       enh, dacc, nacc, unl, wr, rd, fifo_en;
	logic       rxd_pend, txr_pend, rls_pend, msi_pend, div_zero;
	logic [7:0] line_status;
	logic [3:0] isr_code;
	uim_src_t   src;

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] lock, input logic open);
		merge = open ? nw : ((old & lock) | (nw & ~lock));
	endfunction

	function automatic logic hit(input logic [2:0] a, input logic [2:0] b, input logic s);
		hit = s && (a == b);
	endfunction

	assign wr   = ce_i && wr_i;
	assign rd   = ce_i && rd_i;
	assign enh  = (lcr_q == LCR_ENH_KEY);
	assign dacc = lcr_q[LCR_DIV_BIT] && !enh;
	assign nacc = !lcr_q[LCR_DIV_BIT] && !enh;
	assign unl  = efr_q[EFR_UNL_BIT];
	assign fifo_en  = fcr_q[FCR_EN_BIT];
	assign div_zero = (dll_q == RST_ZERO) && (dlm_q == RST_ZERO);

	// ****************************************
	// line control and divisor
	// ****************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lcr_q <= RST_ZERO;
		end else if (wr && addr_i == ADR_LCTL) begin
			lcr_q <= wdata_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dll_q <= RST_ZERO;
			dlm_q <= RST_ZERO;
			dld_q <= RST_ZERO;
		end else begin
			if (hit(addr_i, ADR_DATA, wr && dacc)) begin
				dll_q <= wdata_i;
			end
			if (hit(addr_i, ADR_MASK, wr && dacc)) begin
				dlm_q <= wdata_i;
			end
			if (hit(addr_i, ADR_FIFO, wr && dacc && unl)) begin
				dld_q <= wdata_i & LOW_NIB_MASK;
			end
		end
	end

	// ****************************************
	// mask, fifo and modem control
	// ****************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ier_q <= RST_ZERO;
			fcr_q <= RST_ZERO;
			mcr_q <= RST_ZERO;
			scr_q <= RST_ZERO;
			enhanced_mode_select_q <= RST_ZERO;
		end else begin
			if (hit(addr_i, ADR_MASK, wr && nacc)) begin
				ier_q <= merge(ier_q, wdata_i, UNL_MASK_IER, unl);
			end
			if (hit(addr_i, ADR_FIFO, wr && !enh)) begin
				fcr_q <= merge(fcr_q, wdata_i, UNL_MASK_FCR, unl);
			end
			if (hit(addr_i, ADR_MCTL, wr && !enh)) begin
				mcr_q <= merge(mcr_q, wdata_i, UNL_MASK_MCR, unl);
			end
			if (hit(addr_i, ADR_SCR, wr && !enh)) begin
				if (feature_control_q[FEATURE_CONTROL_SWP_BIT]) begin
					enhanced_mode_select_q <= wdata_i;
				end else begin
					scr_q <= wdata_i;
				end
			end
		end
	end

	// ****************************************
	// enhanced window
	// ****************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			efr_q  <= RST_ZERO;
			feature_control_q <= RST_ZERO;
			rtrg_q <= RST_TRIG;
			ttrg_q <= RST_TRIG;
			res1_q <= RST_ZERO;
			res2_q <= RST_ZERO;
			pau1_q <= RST_ZERO;
			pau2_q <= RST_ZERO;
		end else if (wr && enh) begin
			case (addr_i)
				ADR_DATA: begin
					if (feature_control_q[FEATURE_CONTROL_RXT_BIT]) begin
						rtrg_q <= wdata_i;
					end else begin
						ttrg_q <= wdata_i;
					end
				end
				ADR_MASK: feature_control_q <= wdata_i;
				ADR_FIFO: efr_q  <= wdata_i;
				ADR_RES1: res1_q <= wdata_i;
				ADR_RES2: res2_q <= wdata_i;
				ADR_PAU1: pau1_q <= wdata_i;
				ADR_PAU2: pau2_q <= wdata_i;
				default: ;
			endcase
		end
	end

	// ****************************************
	// line status and error tracking
	// ****************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ovr_q <= 1'b0;
			imm_q <= 1'b0;
		end else if (ce_i) begin
			// overrun sticky, set beats read clear
			ovr_q <= rx_overrun_i || (ovr_q && !hit(addr_i, ADR_LSTS, rd));
			imm_q <= (rx_push_i && |rx_push_err_i && enhanced_mode_select_q[ENHANCED_MODE_SELECT_IMM_BIT])
				|| (imm_q && !hit(addr_i, ADR_LSTS, rd));
		end
	end

	always_comb begin
		line_status = RST_ZERO;
		line_status[0] = (rx_level_i != 7'h00);
		line_status[1] = ovr_q;
		line_status[4:2] = line_status[0] ? rx_top_err_i : 3'h0;
		line_status[5] = (tx_level_i == 7'h00);
		line_status[6] = (tx_level_i == 7'h00) && tx_shift_empty_i;
		line_status[7] = rx_any_err_i;
	end

	// ****************************************
	// interrupt sources
	// ****************************************
	// trigger level in fifo mode
	assign rxd_pend = ier_q[IER_RXD_BIT] && (fifo_en ?
		({1'b0, rx_level_i} >= rtrg_q) : line_status[0]);
	// level driven, so enabling while empty fires
	assign txr_pend = ier_q[IER_TXR_BIT] && (fifo_en ?
		({1'b0, tx_level_i} < ttrg_q) : line_status[5]);
	assign rls_pend = ier_q[IER_RLS_BIT] && (ovr_q || imm_q
		|| (!enhanced_mode_select_q[ENHANCED_MODE_SELECT_IMM_BIT] && |line_status[4:2]));
	assign msi_pend = ier_q[IER_MSI_BIT] && |modem_status_i[3:0];

	uim_prio u_prio (
		.rls_i  (rls_pend),
		.rxd_i  (rxd_pend),
		.txr_i  (txr_pend),
		.msi_i  (msi_pend),
		.src_o  (src),
		.code_o (isr_code)
	);

	// ****************************************
	// read mux
	// ****************************************
	always_comb begin
		rdata_d = RST_ZERO;
		if (enh) begin
			case (addr_i)
				ADR_DATA: rdata_d = feature_control_q[FEATURE_CONTROL_RXT_BIT] ? {1'b0, rx_level_i}
					: {1'b0, tx_level_i};
				ADR_MASK: rdata_d = feature_control_q;
				ADR_FIFO: rdata_d = efr_q;
				ADR_RES1: rdata_d = res1_q;
				ADR_RES2: rdata_d = res2_q;
				ADR_PAU1: rdata_d = pau1_q;
				ADR_PAU2: rdata_d = pau2_q;
				default:  rdata_d = RST_ZERO;
			endcase
		end else begin
			case (addr_i)
				ADR_DATA: rdata_d = dacc ? (div_zero ? REV_ID_VAL : dll_q) : rx_data_i;
				ADR_MASK: rdata_d = dacc ? (div_zero ? DEV_ID_VAL : dlm_q) : ier_q;
				ADR_FIFO: rdata_d = (dacc && unl) ? dld_q
					: {fifo_en, fifo_en, 2'b00, isr_code};
				ADR_LCTL: rdata_d = lcr_q;
				ADR_MCTL: rdata_d = mcr_q;
				ADR_LSTS: rdata_d = line_status;
				ADR_MSTS: rdata_d = modem_status_i;
				ADR_SCR:  rdata_d = feature_control_q[FEATURE_CONTROL_SWP_BIT] ?
					(feature_control_q[FEATURE_CONTROL_RXT_BIT] ? {1'b0, rx_level_i} : {1'b0, tx_level_i})
					: scr_q;
				default:  rdata_d = RST_ZERO;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= RST_ZERO;
		end else if (rd) begin
			rdata_o <= rdata_d;
		end
	end

	// ****************************************
	// strobes to the datapath
	// ****************************************
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_pop_o          <= 1'b0;
			tx_push_o         <= 1'b0;
			tx_data_o         <= RST_ZERO;
			modem_status_rd_o <= 1'b0;
			rx_fifo_rst_o     <= 1'b0;
			tx_fifo_rst_o     <= 1'b0;
		end else if (ce_i) begin
			rx_pop_o          <= hit(addr_i, ADR_DATA, rd && nacc);
			tx_push_o         <= hit(addr_i, ADR_DATA, wr && nacc);
			modem_status_rd_o <= hit(addr_i, ADR_MSTS, rd && !enh);
			rx_fifo_rst_o     <= hit(addr_i, ADR_FIFO, wr && !enh) && wdata_i[FCR_RXR_BIT];
			tx_fifo_rst_o     <= hit(addr_i, ADR_FIFO, wr && !enh) && wdata_i[FCR_TXR_BIT];
			if (hit(addr_i, ADR_DATA, wr && nacc)) begin
				tx_data_o <= wdata_i;
			end
		end
	end

	assign fifo_en_o              = fifo_en;
	assign divisor_o              = {dlm_q, dll_q};
	assign frac_div_o             = unl ? dld_q[3:0] : 4'h0;
	assign line_control_o         = lcr_q;
	assign modem_control_o        = mcr_q;
	assign feature_control_o      = feature_control_q;
	assign enhanced_function_o    = efr_q;
	assign enhanced_mode_select_o = enhanced_mode_select_q;
	assign rx_trigger_o           = rtrg_q;
	assign tx_trigger_o           = ttrg_q;
	assign irq_o                  = (src != SRC_NONE);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	div_window_a: assert property (wr && ce_i && addr_i == ADR_DATA && dacc
		|=> dll_q == $past(wdata_i)) else $error("divisor low not written");
	div_locked_a: assert property (wr && addr_i == ADR_DATA && enh
		|=> $stable(dll_q)) else $error("divisor written under key");
	frac_nibble_a: assert property (dld_q[7:4] == 4'h0)
		else $error("fraction upper bits set");
	ier_lock_a: assert property (wr && addr_i == ADR_MASK && nacc && !unl
		|=> ier_q[7:4] == $past(ier_q[7:4])) else $error("mask upper bits leaked");
	rx_trig_a: assert property (ier_q[0] && fifo_en && {1'b0, rx_level_i} >= rtrg_q
		|-> irq_o) else $error("receive trigger missed");
	data_ready_a: assert property (rd && addr_i == ADR_LSTS && !enh
		|=> rdata_o[0] == ($past(rx_level_i) != 7'h00)) else $error("data ready wrong");
	overrun_set_a: assert property (ce_i && rx_overrun_i |=> ovr_q)
		else $error("overrun lost");
	tx_all_empty_a: assert property (line_status[6] |-> line_status[5] && tx_shift_empty_i)
		else $error("all empty without shifter");
	tx_enable_a: assert property (!ier_q[1] && !fifo_en && line_status[5] && !rls_pend && !rxd_pend
		&& wr && ce_i && addr_i == ADR_MASK && nacc && wdata_i[1] ##1 line_status[5]
		|-> txr_pend && irq_o) else $error("transmit ready not raised");
	rls_ovr_a: assert property (ier_q[2] && ovr_q |-> isr_code == ISR_RLS)
		else $error("overrun not top priority");
	msi_gate_a: assert property (!ier_q[3] |-> src != SRC_MSI)
		else $error("modem interrupt unmasked");
	irq_idle_a: assert property (ier_q[3:0] == 4'h0 |-> !irq_o)
		else $error("interrupt in polled mode");
	efr_key_a: assert property (wr && addr_i == ADR_FIFO && !enh
		|=> $stable(efr_q)) else $error("enhanced written without key");

	cov_rx_c:  cover property (src == SRC_RXD ##1 src == SRC_NONE);
	cov_rls_c: cover property (rx_push_i && |rx_push_err_i && enhanced_mode_select_q[ENHANCED_MODE_SELECT_IMM_BIT]);
	cov_div_c: cover property (rd && addr_i == ADR_DATA && dacc && div_zero);
endmodule

/* File: rtl/uim_pkg.sv */
package uim_pkg;
	// ****************************************
	// bus addresses
	// ****************************************
	localparam logic [2:0] ADR_DATA  = 3'h0;
	localparam logic [2:0] ADR_MASK  = 3'h1;
	localparam logic [2:0] ADR_FIFO  = 3'h2;
	localparam logic [2:0] ADR_LCTL  = 3'h3;
	localparam logic [2:0] ADR_MCTL  = 3'h4;
	localparam logic [2:0] ADR_LSTS  = 3'h5;
	localparam logic [2:0] ADR_MSTS  = 3'h6;
	localparam logic [2:0] ADR_SCR   = 3'h7;
	localparam logic [2:0] ADR_RES1  = 3'h4;
	localparam logic [2:0] ADR_RES2  = 3'h5;
	localparam logic [2:0] ADR_PAU1  = 3'h6;
	localparam logic [2:0] ADR_PAU2  = 3'h7;

	// ****************************************
	// field positions and special values
	// ****************************************
	localparam logic [7:0] LCR_ENH_KEY  = 8'hbf;
	localparam int         LCR_DIV_BIT  = 7;
	localparam int         EFR_UNL_BIT  = 4;
	localparam int         FCR_EN_BIT   = 0;
	localparam int         FCR_RXR_BIT  = 1;
	localparam int         FCR_TXR_BIT  = 2;
	localparam int         FEATURE_CONTROL_SWP_BIT = 6;
	localparam int         FEATURE_CONTROL_RXT_BIT = 7;
	localparam int         ENHANCED_MODE_SELECT_IMM_BIT = 6;
	localparam int         IER_RXD_BIT  = 0;
	localparam int         IER_TXR_BIT  = 1;
	localparam int         IER_RLS_BIT  = 2;
	localparam int         IER_MSI_BIT  = 3;
	localparam logic [7:0] LOW_NIB_MASK = 8'h0f;
	localparam logic [7:0] UNL_MASK_IER = 8'hf0;
	localparam logic [7:0] UNL_MASK_FCR = 8'h30;
	localparam logic [7:0] UNL_MASK_MCR = 8'he0;

	// ****************************************
	// reset values and identity
	// ****************************************
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_TRIG     = 8'h01;
	// arbitrary identity values
	localparam logic [7:0] REV_ID_VAL   = 8'h01;
	localparam logic [7:0] DEV_ID_VAL   = 8'h5c;

	// ****************************************
	// interrupt status codes
	// ****************************************
	localparam logic [3:0] ISR_NONE = 4'h1;
	localparam logic [3:0] ISR_RLS  = 4'h6;
	localparam logic [3:0] ISR_RXD  = 4'h4;
	localparam logic [3:0] ISR_TXR  = 4'h2;
	localparam logic [3:0] ISR_MSI  = 4'h0;

	typedef enum logic [2:0] {SRC_NONE, SRC_RLS, SRC_RXD, SRC_TXR, SRC_MSI} uim_src_t;
endpackage

/* File: rtl/uim_prio.sv */
`timescale 1ns/1ps
module uim_prio
	import uim_pkg::*;
(
	input  wire logic       rls_i,
	input  wire logic       rxd_i,
	input  wire logic       txr_i,
	input  wire logic       msi_i,
	output uim_pkg::uim_src_t src_o,
	output logic [3:0]      code_o
);
	// ****************************************
	// highest pending source wins
	// ****************************************
	always_comb begin
		if (rls_i) begin
			src_o = SRC_RLS;
		end else if (rxd_i) begin
			src_o = SRC_RXD;
		end else if (txr_i) begin
			src_o = SRC_TXR;
		end else if (msi_i) begin
			src_o = SRC_MSI;
		end else begin
			src_o = SRC_NONE;
		end
	end

	always_comb begin
		case (src_o)
			SRC_RLS: code_o = ISR_RLS;
			SRC_RXD: code_o = ISR_RXD;
			SRC_TXR: code_o = ISR_TXR;
			SRC_MSI: code_o = ISR_MSI;
			default: code_o = ISR_NONE;
		endcase
	end
endmodule

/* File: tb/uim_host.sv */
`timescale 1ns/1ps
// ****************************************
// host side register bus model
// ****************************************
module uim_host (
	input  wire logic       core_clk_i,
	input  wire logic [7:0] rdata_i,
	output logic            ce_o,
	output logic [2:0]      addr_o,
	output logic [7:0]      wdata_o,
	output logic            wr_o,
	output logic            rd_o
);
	initial begin
		ce_o = 1'b1;
		addr_o = 3'h0;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// caller selects window; one access per call, read data sampled at the next falling edge
	task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge core_clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(negedge core_clk_i);
		q = rdata_i;
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
endmodule

/* File: tb/test_uim_regs.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("Error %s exp %h got %h", nm, e, g); \
	end \
end
module test_uim_regs;
	import uim_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        ce, wr, rd, irq, fe;
	logic [2:0]  addr;
	logic [7:0]  wdata, rdata, t, d0, d1;
	logic [7:0]  rx_data = 8'h00, modem_st = 8'h00, enh, rx_trig;
	logic [6:0]  rx_level = 7'h00, tx_level = 7'h01, lvl;
	logic [2:0]  rx_top_err = 3'h0, rx_push_err = 3'h0;
	logic        rx_any_err = 1'b0, rx_push = 1'b0, rx_overrun = 1'b0, tx_shift_empty = 1'b0;
	logic [15:0] divisor;
	logic [3:0]  frac;
	logic        pop, push, msrd, rrst, trst, fen;
	logic [7:0]  txd, lctl, mctl, fctl, emsel, tx_trig;
	int          bad_count = 0;
	int          n_checks = 0;

	always #5 core_clk_i = ~core_clk_i;

	uim_host u_uim_host (.core_clk_i(core_clk_i), .rdata_i(rdata), .ce_o(ce), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	uim_regs u_uim_regs (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.rx_data_i(rx_data), .rx_level_i(rx_level), .rx_top_err_i(rx_top_err),
		.rx_any_err_i(rx_any_err), .rx_push_i(rx_push), .rx_push_err_i(rx_push_err),
		.rx_overrun_i(rx_overrun), .tx_level_i(tx_level), .tx_shift_empty_i(tx_shift_empty),
		.modem_status_i(modem_st), .rx_pop_o(pop), .tx_push_o(push), .tx_data_o(txd),
		.modem_status_rd_o(msrd), .rx_fifo_rst_o(rrst), .tx_fifo_rst_o(trst),
		.fifo_en_o(fen), .divisor_o(divisor), .frac_div_o(frac), .line_control_o(lctl),
		.modem_control_o(mctl), .feature_control_o(fctl), .enhanced_function_o(enh),
		.enhanced_mode_select_o(emsel), .rx_trigger_o(rx_trig), .tx_trigger_o(tx_trig),
		.irq_o(irq));

	// ****************************************
	// bus and check helpers
	// ****************************************
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_uim_host.xfer(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string nm);
		logic [7:0] q;
		u_uim_host.xfer(1'b0, a, 8'h00, q);
		`CHK(nm, e, q)
	endtask

	task automatic ck_irq(input logic e);
		#1;
		`CHK("irq", e, irq)
	endtask

	function automatic logic [7:0] interrupt_status(input logic f, input logic [3:0] c);
		return {f, f, 2'b00, c};
	endfunction

	function automatic logic [7:0] line_status(input logic ovr);
		logic te;
		te = (tx_level == 7'h00);
		return {rx_any_err, te & tx_shift_empty, te, rx_top_err, ovr, rx_level != 7'h00};
	endfunction

	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#400000;
		bad_count++;
		end_of_test();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(27077));
		repeat (12) @(posedge core_clk_i);
		@(negedge core_clk_i);
		reset_n_i = 1'b1;
		rdc(ADR_MASK, 8'h00, "mask reset");
		rdc(ADR_FIFO, interrupt_status(1'b0, ISR_NONE), "status reset");
		ck_irq(1'b0);
		wr_reg(ADR_MASK, 8'hff);
		rdc(ADR_MASK, 8'h0f, "mask locked");
		wr_reg(ADR_MASK, 8'h00);
		wr_reg(ADR_LCTL, 8'h80);
		`CHK("line control", 8'h80, lctl)
		d0 = 8'($urandom) | 8'h01;
		d1 = 8'($urandom);
		wr_reg(ADR_DATA, d0);
		wr_reg(ADR_MASK, d1);
		rdc(ADR_DATA, d0, "divisor low");
		rdc(ADR_MASK, d1, "divisor high");
		`CHK("divisor", {d1, d0}, divisor)
		wr_reg(ADR_FIFO, 8'h0e);
		rdc(ADR_FIFO, interrupt_status(1'b0, ISR_NONE), "fraction locked");
		`CHK("fraction", 4'h0, frac)
		wr_reg(ADR_LCTL, LCR_ENH_KEY);
		wr_reg(ADR_DATA, 8'h55);
		`CHK("divisor keyed", {d1, d0}, divisor)
		`CHK("tx trigger", 8'h55, tx_trig)
		wr_reg(ADR_FIFO, 8'h10);
		rdc(ADR_FIFO, 8'h10, "enhanced");
		for (int a = 4; a < 8; a++) begin
			t = 8'($urandom);
			wr_reg(3'(a), t);
			rdc(3'(a), t, "flow char");
		end
		wr_reg(ADR_MASK, 8'h80);
		t = 8'($urandom_range(60, 2));
		wr_reg(ADR_DATA, t);
		wr_reg(ADR_MASK, 8'h00);
		`CHK("rx trigger", t, rx_trig)
		wr_reg(ADR_LCTL, 8'h80);
		wr_reg(ADR_FIFO, 8'hab);
		rdc(ADR_FIFO, 8'h0b, "fraction");
		`CHK("fraction out", 4'hb, frac)
		wr_reg(ADR_LCTL, 8'h00);
		wr_reg(ADR_FIFO, 8'h00);
		`CHK("enhanced kept", 8'h10, enh)
		wr_reg(ADR_MASK, 8'hf0);
		rdc(ADR_MASK, 8'hf0, "mask unlocked");
		wr_reg(ADR_MASK, 8'h00);
		for (int f = 0; f < 2; f++) begin
			fe = f[0];
			wr_reg(ADR_FIFO, {5'h00, 2'b11, fe});
			`CHK("fifo control", {fe, 2'b11}, {fen, trst, rrst})
			wr_reg(ADR_MASK, 8'h01);
			for (int i = 0; i < 10; i++) begin
				@(negedge core_clk_i);
				lvl = (i < 2) ? t[6:0] - 7'd1 + 7'(i) : 7'($urandom_range(63));
				rx_level = lvl;
				rx_data = 8'($urandom);
				ck_irq(fe ? (lvl >= t[6:0]) : (lvl != 7'h00));
			end
			rx_level = t[6:0];
			rdc(ADR_FIFO, interrupt_status(fe, ISR_RXD), "status rx");
			rx_level = 7'h00;
			wr_reg(ADR_MASK, 8'h00);
			tx_level = 7'h00;
			ck_irq(1'b0);
			wr_reg(ADR_MASK, 8'h02);
			ck_irq(1'b1);
			rdc(ADR_FIFO, interrupt_status(fe, ISR_TXR), "status tx");
			@(negedge core_clk_i);
			tx_level = fe ? 7'h55 : 7'h01;
			ck_irq(1'b0);
			wr_reg(ADR_MASK, 8'h00);
		end
		@(negedge core_clk_i);
		rx_level = t[6:0];
		tx_level = 7'h00;
		ck_irq(1'b0);
		wr_reg(ADR_MASK, 8'h04);
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk_i);
			rx_level = 7'($urandom_range(63, 1));
			rx_top_err = 3'($urandom);
			rx_any_err = 1'($urandom);
			tx_level = (i < 3) ? 7'h00 : 7'($urandom_range(63));
			tx_shift_empty = 1'($urandom);
			ck_irq(rx_top_err != 3'h0);
			rdc(ADR_LSTS, line_status(1'b0), "line status");
		end
		@(negedge core_clk_i);
		rx_top_err = 3'h0;
		rx_overrun = 1'b1;
		@(negedge core_clk_i);
		rx_overrun = 1'b0;
		ck_irq(1'b1);
		rdc(ADR_FIFO, interrupt_status(1'b1, ISR_RLS), "status line");
		rdc(ADR_LSTS, line_status(1'b1), "overrun");
		ck_irq(1'b0);
		wr_reg(ADR_LCTL, LCR_ENH_KEY);
		wr_reg(ADR_MASK, 8'h40);
		`CHK("feature", 8'h40, fctl)
		wr_reg(ADR_LCTL, 8'h00);
		wr_reg(ADR_SCR, 8'h40);
		`CHK("mode select", 8'h40, emsel)
		@(negedge core_clk_i);
		rx_push = 1'b1;
		rx_push_err = 3'h2;
		@(negedge core_clk_i);
		rx_push = 1'b0;
		rx_push_err = 3'h0;
		ck_irq(1'b1);
		rdc(ADR_LSTS, line_status(1'b0), "line status imm");
		ck_irq(1'b0);
		wr_reg(ADR_MASK, 8'h00);
		@(negedge core_clk_i);
		modem_st = 8'h01;
		ck_irq(1'b0);
		wr_reg(ADR_MASK, 8'h08);
		ck_irq(1'b1);
		rdc(ADR_FIFO, interrupt_status(1'b1, ISR_MSI), "status modem");
		@(negedge core_clk_i);
		modem_st = 8'h00;
		ck_irq(1'b0);
		wr_reg(ADR_DATA, t);
		`CHK("tx push", {1'b1, t}, {push, txd})
		rdc(ADR_DATA, rx_data, "rx data");
		`CHK("rx pop", 1'b1, pop)
		rdc(ADR_MSTS, modem_st, "modem status");
		`CHK("modem read", 1'b1, msrd)
		wr_reg(ADR_MCTL, 8'hff);
		`CHK("modem control", 8'hff, mctl)
		end_of_test();
	end
endmodule
